// *** sim/dhbp_asserts.sv ***
// Pin-level checks between host and device ends
module dhbp_asserts (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic style_sel,
  input wire logic data_host_oe_n,
  input wire logic data_dev_oe_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_a_irq_o,
  input wire logic chan_a_irq_oe_n,
  input wire logic chan_b_irq_oe_n,
  input wire logic chan_a_gp_output2_n,
  input wire logic chan_b_gp_output2_n
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_strobe_rd;
    style_sel && !(chan_a_select_n && chan_b_select_n) && $fell(read_strobe_n);
  endsequence
  sequence s_select_rd;
    !style_sel && write_strobe_n && $fell(chan_a_select_n);
  endsequence
  sequence s_dev_drives;
    ##[1:6] !data_dev_oe_n;
  endsequence
  a_one_driver: assert property (data_dev_oe_n || data_host_oe_n)
    else $error("host and device drive data together");
  a_reset_outs: assert property ($fell(srst_in) |-> chan_b_gp_output2_n && chan_b_irq_oe_n && data_dev_oe_n)
    else $error("outputs not at reset state");
  a_strobe_read: assert property (s_strobe_rd |-> s_dev_drives)
    else $error("strobe read not driven");
  a_select_read: assert property (s_select_rd |-> s_dev_drives)
    else $error("select read not driven");
  a_no_select: assert property ((style_sel && chan_a_select_n && chan_b_select_n) [*6] |-> data_dev_oe_n)
    else $error("data driven without select");
  a_select_write: assert property ((!style_sel && !chan_a_select_n && !write_strobe_n) [*4] |-> data_dev_oe_n)
    else $error("data driven during write");
  a_rd_tied: assert property (!style_sel && $past(!style_sel) |-> read_strobe_n)
    else $error("read strobe not held high");
  a_irq_a_out2: assert property (style_sel && $past(style_sel) |-> chan_a_irq_oe_n == chan_a_gp_output2_n)
    else $error("irq a enable and gp2 a disagree");
  a_irq_b_out2: assert property (chan_b_irq_oe_n == chan_b_gp_output2_n)
    else $error("irq b enable and gp2 b disagree");
  a_open_drain: assert property (!style_sel && !chan_a_irq_oe_n |-> !chan_a_irq_o)
    else $error("device irq driven high");
endmodule

// *** sim/dual_uart_host_bus_port_tb_top.sv ***
// Testbench joining host and device ends through the pin interface
module dual_uart_host_bus_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dhbp_pkg::*;
  logic       core_clk_in = 1'b0;
  logic       srst_in     = 1'b1;
  logic       style_in    = 1'b1;
  logic       valid_in    = 1'b0;
  logic       write_in    = 1'b0;
  logic       chan_in     = 1'b0;
  logic [2:0] addr_in     = 3'h0;
  logic [7:0] wdata_in    = 8'h00;
  logic [1:0] irq_req     = 2'h0;
  logic [3:0] rdy_in      = 4'h0;
  logic       req_ready;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;
  logic [7:0] mcr_a;
  logic [7:0] mcr_b;
  logic [7:0] rd;
  int         miscompares = 0;
  int         checks      = 0;
  dhbp_if i_dhbp_if ();
  always #4 core_clk_in = ~core_clk_in;
  dhbp_device i_dhbp_device (.core_clk_in(core_clk_in), .srst_in(srst_in), .bus(i_dhbp_if.device),
    .chan_a_irq_req_in(irq_req[0]), .chan_b_irq_req_in(irq_req[1]), .chan_a_tx_ready_in(rdy_in[0]),
    .chan_a_rx_ready_in(rdy_in[1]), .chan_b_tx_ready_in(rdy_in[2]), .chan_b_rx_ready_in(rdy_in[3]),
    .chan_a_mcr_out(mcr_a), .chan_b_mcr_out(mcr_b));
  dhbp_host i_dhbp_host (.core_clk_in(core_clk_in), .srst_in(srst_in), .bus(i_dhbp_if.host),
    .style_sel_in(style_in), .req_valid_in(valid_in), .req_write_in(write_in), .req_chan_in(chan_in),
    .req_addr_in(addr_in), .req_wdata_in(wdata_in), .req_ready_out(req_ready), .rsp_valid_out(rsp_valid),
    .rsp_rdata_out(rsp_rdata));
  dhbp_asserts i_dhbp_asserts (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .style_sel(i_dhbp_if.style_sel), .data_host_oe_n(i_dhbp_if.data_host_oe_n),
    .data_dev_oe_n(i_dhbp_if.data_dev_oe_n), .read_strobe_n(i_dhbp_if.read_strobe_n),
    .write_strobe_n(i_dhbp_if.write_strobe_n), .chan_a_select_n(i_dhbp_if.chan_a_select_n),
    .chan_b_select_n(i_dhbp_if.chan_b_select_n), .chan_a_irq_o(i_dhbp_if.chan_a_irq_o),
    .chan_a_irq_oe_n(i_dhbp_if.chan_a_irq_oe_n), .chan_b_irq_oe_n(i_dhbp_if.chan_b_irq_oe_n),
    .chan_a_gp_output2_n(i_dhbp_if.chan_a_gp_output2_n), .chan_b_gp_output2_n(i_dhbp_if.chan_b_gp_output2_n));
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Bounded wait step; a hang ends the run as a mismatch
  task automatic tick(inout int n);
    @(negedge core_clk_in);
    n++;
    if (n > 40) begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic xfer(input logic w, input logic c, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) tick(n);
    valid_in = 1'b1;
    write_in = w;
    chan_in  = c;
    addr_in  = a;
    wdata_in = d;
    @(negedge core_clk_in);
    valid_in = 1'b0;
    n = 0;
    while (!w && rsp_valid !== 1'b1) tick(n);
    rd = rsp_rdata;
  endtask
  initial begin
    repeat (2) @(negedge core_clk_in);
    srst_in = 1'b0;
    @(negedge core_clk_in);
    cmp1("gp2 b", 1'b1, i_dhbp_if.chan_b_gp_output2_n);
    cmp8("mcr b", REG_RESET, mcr_b);
    cmp1("irq b oe", 1'b1, i_dhbp_if.chan_b_irq_oe_n);
    // Bit 3 kept clear so the output-2 control stays off here
    for (int c = 0; c < 2; c++) begin
      for (int a = 0; a < 8; a++) xfer(1'b1, c[0], a[2:0], {1'b1, c[0], 3'h0, a[2:0]});
    end
    for (int c = 0; c < 2; c++) begin
      for (int a = 0; a < 8; a++) begin
        xfer(1'b0, c[0], a[2:0], 8'h00);
        cmp8("read", {1'b1, c[0], 3'h0, a[2:0]}, rd);
      end
    end
    cmp8("mcr a", 8'h84, mcr_a);
    xfer(1'b1, 1'b0, MCR_ADDR, 8'h08);
    irq_req = 2'h1;
    // Write lands about nine cycles after the take
    repeat (10) @(negedge core_clk_in);
    cmp1("gp2 a", 1'b0, i_dhbp_if.chan_a_gp_output2_n);
    cmp1("irq a oe", 1'b0, i_dhbp_if.chan_a_irq_oe_n);
    cmp1("irq a", 1'b1, i_dhbp_if.chan_a_irq_o);
    cmp1("gp2 b", 1'b1, i_dhbp_if.chan_b_gp_output2_n);
    irq_req = 2'h0;
    xfer(1'b1, 1'b1, MCR_ADDR, 8'h08);
    xfer(1'b1, 1'b0, MCR_ADDR, 8'h00);
    repeat (10) @(negedge core_clk_in);
    cmp1("gp2 b", 1'b0, i_dhbp_if.chan_b_gp_output2_n);
    cmp1("irq b oe", 1'b0, i_dhbp_if.chan_b_irq_oe_n);
    cmp1("irq a oe", 1'b1, i_dhbp_if.chan_a_irq_oe_n);
    for (int i = 0; i < 4; i++) begin
      rdy_in = 4'(1 << i);
      @(negedge core_clk_in);
      cmp8("ready_n", {4'h0, ~rdy_in}, {4'h0, i_dhbp_if.chan_b_rx_ready_n, i_dhbp_if.chan_b_tx_ready_n,
        i_dhbp_if.chan_a_rx_ready_n, i_dhbp_if.chan_a_tx_ready_n});
    end
    style_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    xfer(1'b1, 1'b0, 3'h2, 8'hc3);
    xfer(1'b1, 1'b1, 3'h2, 8'h3c);
    xfer(1'b0, 1'b0, 3'h2, 8'h00);
    cmp8("sel read a", 8'hc3, rd);
    xfer(1'b0, 1'b1, 3'h2, 8'h00);
    cmp8("sel read b", 8'h3c, rd);
    xfer(1'b0, 1'b1, 3'h1, 8'h00);
    cmp8("sel read b1", 8'hc1, rd);
    irq_req = 2'h2;
    repeat (4) @(negedge core_clk_in);
    cmp1("irq pull", 1'b0, i_dhbp_if.chan_a_irq_oe_n);
    irq_req = 2'h0;
    repeat (4) @(negedge core_clk_in);
    cmp1("irq release", 1'b1, i_dhbp_if.chan_a_irq_oe_n);
    srst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    srst_in = 1'b0;
    @(negedge core_clk_in);
    cmp8("mcr b reset", REG_RESET, mcr_b);
    cmp1("gp2 b reset", 1'b1, i_dhbp_if.chan_b_gp_output2_n);
    end_sim();
  end
endmodule

// *** verilog/dhbp_device.sv ***
// Device end: register access over the host pins, irq and ready pins
module dhbp_device
  import dhbp_pkg::*;
(
  input  wire logic  core_clk_in,
  input  wire logic  srst_in,
  dhbp_if.device     bus,
  input  wire logic  chan_a_irq_req_in,
  input  wire logic  chan_b_irq_req_in,
  input  wire logic  chan_a_tx_ready_in,
  input  wire logic  chan_a_rx_ready_in,
  input  wire logic  chan_b_tx_ready_in,
  input  wire logic  chan_b_rx_ready_in,
  output logic [7:0] chan_a_mcr_out,
  output logic [7:0] chan_b_mcr_out
);
  logic [7:0] regs_reg  [2][REG_NUM];
  logic [7:0] regs_next [2][REG_NUM];
  // Two-flop synchronisers for every pin from the host except data_host_oe_n
  logic [15:0] sy1_reg, sy2_reg, sy1_next, sy2_next;
  logic        rd_n, wr_n, csa_n, csb_n, style;
  logic [2:0]  addr;
  logic [7:0]  din;
  logic        rd_act, wr_act, rd_d_reg, rd_d_next, wr_d_reg, wr_d_next, sel_ch;
  logic        ch_ok;
  logic [7:0]  dout_reg, dout_next;
  logic        doe_reg, doe_next;

  always_comb begin
    sy1_next = {bus.style_sel, bus.addr, bus.data_host, bus.read_strobe_n, bus.write_strobe_n,
                bus.chan_a_select_n, bus.chan_b_select_n};
    sy2_next = sy1_reg;
  end
  assign {style, addr, din, rd_n, wr_n, csa_n, csb_n} = sy2_reg;

  always_comb begin
    ch_ok  = 1'b0;
    sel_ch = 1'b0;
    rd_act = 1'b0;
    wr_act = 1'b0;
    if (style) begin
      ch_ok  = !csa_n || !csb_n;
      sel_ch = csa_n;
      rd_act = ch_ok && !rd_n;
      wr_act = ch_ok && !wr_n;
    end else begin
      ch_ok  = !csa_n;
      sel_ch = csb_n;
      rd_act = ch_ok && wr_n;
      wr_act = ch_ok && !wr_n;
    end
  end

  always_comb begin
    regs_next = regs_reg;
    rd_d_next = rd_act;
    wr_d_next = wr_act;
    dout_next = dout_reg;
    doe_next  = !rd_act;
    if (rd_act && !rd_d_reg)
      dout_next = regs_reg[sel_ch][addr];
    // Latch on strobe release; in select style, on select release
    if (wr_d_reg && !wr_act)
      regs_next[sel_ch][addr] = din;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sy1_reg  <= '1;
      sy2_reg  <= '1;
      rd_d_reg <= 1'b0;
      wr_d_reg <= 1'b0;
      dout_reg <= REG_RESET;
      doe_reg  <= 1'b1;
      for (int c = 0; c < 2; c++)
        for (int r = 0; r < REG_NUM; r++)
          regs_reg[c][r] <= REG_RESET;
    end else begin
      sy1_reg  <= sy1_next;
      sy2_reg  <= sy2_next;
      rd_d_reg <= rd_d_next;
      wr_d_reg <= wr_d_next;
      dout_reg <= dout_next;
      doe_reg  <= doe_next;
      regs_reg <= regs_next;
    end
  end

  assign bus.data_dev      = dout_reg;
  assign bus.data_dev_oe_n = doe_reg;
  assign chan_a_mcr_out    = regs_reg[0][MCR_ADDR];
  assign chan_b_mcr_out    = regs_reg[1][MCR_ADDR];

  always_comb begin
    bus.chan_a_gp_output2_n = !chan_a_mcr_out[MCR_OUT2];
    bus.chan_b_gp_output2_n = !chan_b_mcr_out[MCR_OUT2];
    bus.chan_b_irq_o        = chan_b_irq_req_in;
    bus.chan_b_irq_oe_n     = !chan_b_mcr_out[MCR_OUT2];
    if (style) begin
      bus.chan_a_irq_o    = chan_a_irq_req_in;
      bus.chan_a_irq_oe_n = !chan_a_mcr_out[MCR_OUT2];
    end else begin
      // Open drain: pull low only while any channel requests
      bus.chan_a_irq_o    = 1'b0;
      bus.chan_a_irq_oe_n = !(chan_a_irq_req_in || chan_b_irq_req_in);
    end
    bus.chan_a_tx_ready_n = !chan_a_tx_ready_in;
    bus.chan_b_tx_ready_n = !chan_b_tx_ready_in;
    bus.chan_a_rx_ready_n = !chan_a_rx_ready_in;
    bus.chan_b_rx_ready_n = !chan_b_rx_ready_in;
  end
endmodule

// *** verilog/dhbp_host.sv ***
// Host end: runs one register read or write over the pins per request
module dhbp_host
  import dhbp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        srst_in,
  dhbp_if.host             bus,
  input  wire logic        style_sel_in,
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic        req_chan_in,
  input  wire logic [2:0]  req_addr_in,
  input  wire logic [7:0]  req_wdata_in,
  output logic             req_ready_out,
  output logic             rsp_valid_out,
  output logic [7:0]       rsp_rdata_out
);
  dhbp_state_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       wr_reg, wr_next, ch_reg, ch_next;
  logic [2:0] addr_reg, addr_next;
  logic [7:0] wd_reg, wd_next, rd_reg, rd_next;
  logic       rv_reg, rv_next;

  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    wr_next   = wr_reg;
    ch_next   = ch_reg;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    rd_next   = rd_reg;
    rv_next   = 1'b0;
    case (st_reg)
      DHBP_IDLE: if (req_valid_in) begin
        wr_next   = req_write_in;
        ch_next   = req_chan_in;
        addr_next = req_addr_in;
        wd_next   = req_wdata_in;
        cnt_next  = 3'(SETUP_CYC - 1);
        st_next   = DHBP_SETUP;
      end
      DHBP_SETUP: if (cnt_reg == 3'h0) begin
        cnt_next = 3'(STROBE_CYC - 1);
        st_next  = DHBP_STROBE;
      end else cnt_next = cnt_reg - 3'h1;
      DHBP_STROBE: if (cnt_reg == 3'h0) begin
        // Sample at strobe release; device data is on this clock already
        rd_next  = bus.data_dev;
        rv_next  = !wr_reg;
        cnt_next = 3'(HOLD_CYC - 1);
        st_next  = DHBP_HOLD;
      end else cnt_next = cnt_reg - 3'h1;
      DHBP_HOLD: if (cnt_reg == 3'h0) st_next = DHBP_IDLE;
      else cnt_next = cnt_reg - 3'h1;
      default: st_next = DHBP_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st_reg     <= DHBP_IDLE;
      cnt_reg    <= 3'h0;
      wr_reg     <= 1'b0;
      ch_reg     <= 1'b0;
      addr_reg   <= 3'h0;
      wd_reg     <= 8'h00;
      rd_reg     <= 8'h00;
      rv_reg     <= 1'b0;
    end else begin
      st_reg     <= st_next;
      cnt_reg    <= cnt_next;
      wr_reg     <= wr_next;
      ch_reg     <= ch_next;
      addr_reg   <= addr_next;
      wd_reg     <= wd_next;
      rd_reg     <= rd_next;
      rv_reg     <= rv_next;
    end
  end

  logic busy, strobe;
  assign busy   = (st_reg != DHBP_IDLE);
  assign strobe = (st_reg == DHBP_STROBE);

  always_comb begin
    bus.style_sel      = style_sel_in;
    bus.addr           = addr_reg;
    bus.data_host      = wd_reg;
    bus.data_host_oe_n = !(busy && wr_reg);
    if (style_sel_in) begin
      bus.chan_a_select_n = !(busy && !ch_reg);
      bus.chan_b_select_n = !(busy && ch_reg);
      bus.read_strobe_n   = !(strobe && !wr_reg);
      bus.write_strobe_n  = !(strobe && wr_reg);
    end else begin
      bus.chan_a_select_n = !strobe;
      bus.chan_b_select_n = ch_reg;
      bus.read_strobe_n   = 1'b1;
      bus.write_strobe_n  = !wr_reg;
    end
  end

  assign req_ready_out = !busy;
  assign rsp_valid_out = rv_reg;
  assign rsp_rdata_out = rd_reg;
endmodule

// *** verilog/dhbp_if.sv ***
// Pin-level interface joining host and device ends
interface dhbp_if;
  import dhbp_pkg::*;
  logic              style_sel;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] data_host;
  logic              data_host_oe_n;
  logic [DATA_W-1:0] data_dev;
  logic              data_dev_oe_n;
  logic              read_strobe_n;
  logic              write_strobe_n;
  logic              chan_a_select_n;
  logic              chan_b_select_n;
  logic              chan_a_irq_o;
  logic              chan_a_irq_oe_n;
  logic              chan_b_irq_o;
  logic              chan_b_irq_oe_n;
  logic              chan_a_gp_output2_n;
  logic              chan_b_gp_output2_n;
  logic              chan_a_tx_ready_n;
  logic              chan_a_rx_ready_n;
  logic              chan_b_tx_ready_n;
  logic              chan_b_rx_ready_n;
  modport device (
    input  style_sel, addr, data_host, data_host_oe_n, read_strobe_n, write_strobe_n,
    input  chan_a_select_n, chan_b_select_n,
    output data_dev, data_dev_oe_n, chan_a_irq_o, chan_a_irq_oe_n, chan_b_irq_o,
    output chan_b_irq_oe_n, chan_a_gp_output2_n, chan_b_gp_output2_n,
    output chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n
  );
  modport host (
    output style_sel, addr, data_host, data_host_oe_n, read_strobe_n, write_strobe_n,
    output chan_a_select_n, chan_b_select_n,
    input  data_dev, data_dev_oe_n, chan_a_irq_o, chan_a_irq_oe_n, chan_b_irq_o,
    input  chan_b_irq_oe_n, chan_a_gp_output2_n, chan_b_gp_output2_n,
    input  chan_a_tx_ready_n, chan_a_rx_ready_n, chan_b_tx_ready_n, chan_b_rx_ready_n
  );
endinterface

// *** verilog/dhbp_pkg.sv ***
// Constants and types shared by both ends of the dual channel host bus port
package dhbp_pkg;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned REG_NUM   = 8;
  localparam logic [2:0]  MCR_ADDR  = 3'h4;
  localparam int unsigned MCR_OUT2  = 3;
  localparam logic [7:0]  REG_RESET = 8'h00;
  // Strobe phase lengths, in core clocks, of the host side
  localparam int unsigned SETUP_CYC  = 2;
  localparam int unsigned STROBE_CYC = 4;
  localparam int unsigned HOLD_CYC   = 2;
  typedef enum logic [1:0] {
    DHBP_IDLE,
    DHBP_SETUP,
    DHBP_STROBE,
    DHBP_HOLD
  } dhbp_state_t;
endpackage
